// [fodac_pkg.sv]
// Shared constants for the object dictionary access block: object table,
// error codes, value encodings and start-up timing.
// Assumes a single 125 MHz clock domain; all users import fodac_pkg::*.
`default_nettype none
package fodac_pkg;
  // Reply value field and request keys
  localparam int VALUE_BYTES = 40;
  localparam int VALUE_W = VALUE_BYTES * 8;
  localparam logic [15:0] NULL_INDEX = 16'h0000;
  localparam logic [7:0] NULL_SUBINDEX = 8'h00;

  // Error codes; zero means the access worked
  localparam logic [7:0] ERR_OK = 8'h00;
  localparam logic [7:0] ERR_NO_OBJECT = 8'h01;
  localparam logic [7:0] ERR_ACCESS = 8'h02;
  localparam logic [7:0] ERR_RANGE = 8'h03;

  // Start-up delay before measured values are emitted
  localparam longint CLK_FREQ_HZ = 125_000_000;
  localparam longint START_DELAY_MS = 2000;
  localparam int START_DELAY_CYCLES = int'(START_DELAY_MS * CLK_FREQ_HZ / 1000);

  typedef enum logic [2:0] {
    float32_type, signed16_type, signed32_type, unsigned8_type,
    unsigned16_type, unsigned32_type, boolean_type
  } fodac_type_t;

  typedef enum logic [1:0] {ACC_RO, ACC_WO, ACC_RW} fodac_access_t;

  // Object table: {object_index, object_subindex}, encoding, rights, start value
  localparam int NUM_OBJECTS = 8;
  localparam int SLOT_W = 3;
  localparam logic [23:0] OBJ_KEY [NUM_OBJECTS] = '{
    24'h1010_01, 24'h2010_07, 24'h2010_16, 24'h2010_17,
    24'h2010_18, 24'h3002_02, 24'h3143_00, 24'h2100_01};
  localparam fodac_type_t OBJ_TYPE [NUM_OBJECTS] = '{
    unsigned32_type, unsigned8_type, unsigned8_type, unsigned16_type,
    float32_type, unsigned8_type, float32_type, unsigned32_type};
  localparam fodac_access_t OBJ_ACC [NUM_OBJECTS] = '{
    ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RW, ACC_RO, ACC_RW, ACC_RW};
  localparam logic [31:0] OBJ_RESET [NUM_OBJECTS] = '{
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_000A,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  // Network settings survive an archive import
  localparam logic OBJ_KEEP [NUM_OBJECTS] = '{
    1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  // Does a 40-byte value field hold a legal value of the given encoding
  function automatic logic fodac_fits(fodac_type_t t, logic [VALUE_W-1:0] v);
    logic ok;
    ok = 1'b0;
    unique case (t)
      float32_type, signed32_type, unsigned32_type: ok = (v[VALUE_W-1:32] == '0);
      signed16_type: ok = (v[VALUE_W-1:32] == '0) && (v[31:16] == {16{v[15]}});
      unsigned16_type: ok = (v[VALUE_W-1:16] == '0);
      unsigned8_type: ok = (v[VALUE_W-1:8] == '0);
      boolean_type: ok = (v[VALUE_W-1:1] == '0);
    endcase
    return ok;
  endfunction

  // Lowest matching entry wins; keys are unique so at most one matches
  function automatic logic [SLOT_W-1:0] fodac_encode(logic [NUM_OBJECTS-1:0] hits);
    logic [SLOT_W-1:0] s;
    s = '0;
    for (int i = NUM_OBJECTS - 1; i >= 0; i--) begin
      if (hits[i]) begin
        s = SLOT_W'(i);
      end
    end
    return s;
  endfunction
endpackage
`default_nettype wire

// [fodac_object_store.sv]
// Small memory holding the current 32-bit contents of each object.
// Assumes one clock; read data appear one edge after the address.
`default_nettype none
module fodac_object_store #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [$clog2(DEPTH)-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  // Registered read port, no reset needed on storage
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// [fodac_object_access.sv]
// Object dictionary request/reply engine behind the cyclic fieldbus modules.
// Assumes request ports are synchronous to clk and stand for one cycle each.
// Contract
// - Read reply echoes index and subindex plus a one-byte error code.
// - Read reply carries a 40-byte value field with current object contents.
// - After each request a null request must come before another is accepted.
// - Write reply echoes index, subindex and error code, no value.
// - Objects are selected only by index and subindex together.
// - Each object is read-only, write-only or read-write, and that is enforced.
// - Values use float32, signed 16/32, unsigned 8/16/32 or Boolean encodings.
// - Start set loads at power-up; measured values flow about 2 s later.
// - At most one network connection, Ethernet or fieldbus, is active.
// - Archive import overwrites everything except the network settings.
// - Measured values go to the controller as floating-point numbers.
`default_nettype none
module fodac_object_access
  import fodac_pkg::*;
#(
  parameter int unsigned START_CYCLES = fodac_pkg::START_DELAY_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [1:0] connReq,
  output logic [1:0] connGrant,
  output logic connRejected,
  input wire logic rdReqValid,
  input wire logic [15:0] rdObjectIndex,
  input wire logic [7:0] rdObjectSubindex,
  input wire logic wrReqValid,
  input wire logic [15:0] wrObjectIndex,
  input wire logic [7:0] wrObjectSubindex,
  input wire logic [fodac_pkg::VALUE_W-1:0] wrValue,
  input wire logic importValid,
  input wire logic [15:0] importObjectIndex,
  input wire logic [7:0] importObjectSubindex,
  input wire logic [31:0] importValue,
  input wire logic [31:0] measFloat,
  output logic [31:0] measFloatOut,
  output logic measActive,
  output logic reqReady,
  output logic rdReplyValid,
  output logic [15:0] rdReplyIndex,
  output logic [7:0] rdReplySubindex,
  output logic [7:0] rdReplyError,
  output logic [fodac_pkg::VALUE_W-1:0] rdReplyValue,
  output logic wrReplyValid,
  output logic [15:0] wrReplyIndex,
  output logic [7:0] wrReplySubindex,
  output logic [7:0] wrReplyError
);
  import fodac_pkg::*;

  typedef enum logic [2:0] {S_INIT, S_IDLE, S_RD_WAIT, S_RD_DONE, S_WAIT_NULL} fodac_state_t;

  typedef struct packed {
    fodac_state_t state;
    logic [31:0] startCnt;
    logic started;
    logic [SLOT_W-1:0] slot;
    logic memWe;
    logic [SLOT_W-1:0] memWaddr;
    logic [31:0] memWdata;
    logic [1:0] connGrant;
    logic [1:0] connReqPrev;
    logic connRejected;
    logic [23:0] pendKey;
    logic rdValid;
    logic [15:0] rdIdx;
    logic [7:0] rdSub;
    logic [7:0] rdErr;
    logic [VALUE_W-1:0] rdVal;
    logic wrValid;
    logic [15:0] wrIdx;
    logic [7:0] wrSub;
    logic [7:0] wrErr;
    logic [31:0] measOut;
  } fodac_regs_t;

  fodac_regs_t q, d;
  logic [31:0] memRdata;
  logic [NUM_OBJECTS-1:0] rdHits, wrHits, impHits;
  logic [SLOT_W-1:0] rdSlot, wrSlot, impSlot;
  logic enable, rdNull, wrNull, takeRd, takeWr;

  // Key match per table entry: both index and subindex must agree
  for (genvar g = 0; g < NUM_OBJECTS; g++) begin : g_match
    assign rdHits[g] = ({rdObjectIndex, rdObjectSubindex} == OBJ_KEY[g]);
    assign wrHits[g] = ({wrObjectIndex, wrObjectSubindex} == OBJ_KEY[g]);
    assign impHits[g] = ({importObjectIndex, importObjectSubindex} == OBJ_KEY[g]);
  end

  // Requests count only while the fieldbus owns the link and start-up is over
  assign enable = q.started && q.connGrant[1];
  assign rdNull = (rdObjectIndex == NULL_INDEX) && (rdObjectSubindex == NULL_SUBINDEX);
  assign wrNull = (wrObjectIndex == NULL_INDEX) && (wrObjectSubindex == NULL_SUBINDEX);
  assign takeRd = enable && rdReqValid && q.state == S_IDLE && !rdNull;
  assign takeWr = enable && wrReqValid && !rdReqValid && q.state == S_IDLE && !wrNull;
  assign rdSlot = fodac_encode(rdHits);
  assign wrSlot = fodac_encode(wrHits);
  assign impSlot = fodac_encode(impHits);

  fodac_object_store #(.DEPTH(NUM_OBJECTS), .WIDTH(32)) u_store (
    .clk(clk),
    .we(q.memWe),
    .waddr(q.memWaddr),
    .wdata(q.memWdata),
    .raddr(q.slot),
    .rdata(memRdata)
  );

  // Next-state logic for the whole block
  always_comb begin
    d = q;
    d.memWe = 1'b0;
    d.rdValid = 1'b0;
    d.wrValid = 1'b0;
    d.connRejected = 1'b0;
    // One connection at a time; a second requester is turned away
    d.connReqPrev = connReq;
    if (q.connGrant == 2'b00) begin
      if (connReq[0]) begin
        d.connGrant = 2'b01;
      end else if (connReq[1]) begin
        d.connGrant = 2'b10;
      end
    end else if ((q.connGrant & connReq) == 2'b00) begin
      d.connGrant = 2'b00;
    end else if ((connReq & ~q.connReqPrev & ~q.connGrant) != 2'b00) begin
      d.connRejected = 1'b1;
    end
    // Start-up timer gates measured values
    if (!q.started) begin
      if (q.startCnt == 32'(START_CYCLES - 1)) begin
        d.started = 1'b1;
      end else begin
        d.startCnt = q.startCnt + 32'h0000_0001;
      end
    end
    if (q.started) begin
      d.measOut = measFloat;
    end
    unique case (q.state)
      // Load the start parameter set, one object per cycle
      S_INIT: begin
        d.memWe = 1'b1;
        d.memWaddr = q.slot;
        d.memWdata = OBJ_RESET[q.slot];
        d.slot = q.slot + SLOT_W'(1);
        if (q.slot == SLOT_W'(NUM_OBJECTS - 1)) begin
          d.state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (enable && rdReqValid && rdNull) begin
          d.rdValid = 1'b1;
          d.rdIdx = NULL_INDEX;
          d.rdSub = NULL_SUBINDEX;
          d.rdErr = ERR_OK;
          d.rdVal = '0;
        end else if (takeRd) begin
          d.pendKey = {rdObjectIndex, rdObjectSubindex};
          d.state = S_WAIT_NULL;
          if (rdHits == '0 || OBJ_ACC[rdSlot] == ACC_WO) begin
            d.rdValid = 1'b1;
            d.rdIdx = rdObjectIndex;
            d.rdSub = rdObjectSubindex;
            d.rdErr = (rdHits == '0) ? ERR_NO_OBJECT : ERR_ACCESS;
            d.rdVal = '0;
          end else begin
            d.slot = rdSlot;
            d.state = S_RD_WAIT;
          end
        end else if (enable && wrReqValid && wrNull) begin
          d.wrValid = 1'b1;
          d.wrIdx = NULL_INDEX;
          d.wrSub = NULL_SUBINDEX;
          d.wrErr = ERR_OK;
        end else if (takeWr) begin
          d.wrValid = 1'b1;
          d.wrIdx = wrObjectIndex;
          d.wrSub = wrObjectSubindex;
          d.state = S_WAIT_NULL;
          if (wrHits == '0) begin
            d.wrErr = ERR_NO_OBJECT;
          end else if (OBJ_ACC[wrSlot] == ACC_RO) begin
            d.wrErr = ERR_ACCESS;
          end else if (!fodac_fits(OBJ_TYPE[wrSlot], wrValue)) begin
            d.wrErr = ERR_RANGE;
          end else begin
            d.wrErr = ERR_OK;
            d.memWe = 1'b1;
            d.memWaddr = wrSlot;
            d.memWdata = wrValue[31:0];
          end
        end else if (importValid && impHits != '0 && !OBJ_KEEP[impSlot]) begin
          d.memWe = 1'b1;
          d.memWaddr = impSlot;
          d.memWdata = importValue;
        end
      end
      // Memory answers one edge after the slot is registered
      S_RD_WAIT: d.state = S_RD_DONE;
      S_RD_DONE: begin
        d.rdValid = 1'b1;
        d.rdIdx = q.pendKey[23:8];
        d.rdSub = q.pendKey[7:0];
        d.rdErr = ERR_OK;
        d.rdVal = {{(VALUE_W - 32){1'b0}}, memRdata};
        d.state = S_WAIT_NULL;
      end
      // Only a null request releases the engine; others are dropped
      S_WAIT_NULL: begin
        if (enable && rdReqValid && rdNull) begin
          d.rdValid = 1'b1;
          d.rdIdx = NULL_INDEX;
          d.rdSub = NULL_SUBINDEX;
          d.rdErr = ERR_OK;
          d.rdVal = '0;
          d.state = S_IDLE;
        end else if (enable && wrReqValid && !rdReqValid && wrNull) begin
          d.wrValid = 1'b1;
          d.wrIdx = NULL_INDEX;
          d.wrSub = NULL_SUBINDEX;
          d.wrErr = ERR_OK;
          d.state = S_IDLE;
        end
      end
    endcase
  end

  // State register; reset clears replies so outputs are defined at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q <= '0;
      q.state <= S_INIT;
    end else begin
      q <= d;
    end
  end

  assign connGrant = q.connGrant;
  assign connRejected = q.connRejected;
  assign measFloatOut = q.measOut;
  assign measActive = q.started;
  assign reqReady = (q.state == S_IDLE) && q.started;
  assign rdReplyValid = q.rdValid;
  assign rdReplyIndex = q.rdIdx;
  assign rdReplySubindex = q.rdSub;
  assign rdReplyError = q.rdErr;
  assign rdReplyValue = q.rdVal;
  assign wrReplyValid = q.wrValid;
  assign wrReplyIndex = q.wrIdx;
  assign wrReplySubindex = q.wrSub;
  assign wrReplyError = q.wrErr;

  // Checks on the request and reply sequences
  sequence s_read_taken;
    takeRd && rdHits != '0 && OBJ_ACC[rdSlot] != ACC_WO;
  endsequence
  sequence s_write_taken;
    takeWr;
  endsequence

  a_read_echo: assert property (@(posedge clk) disable iff (sys_rst)
    s_read_taken |-> ##3 rdReplyValid && rdReplyIndex == $past(rdObjectIndex, 3)
      && rdReplySubindex == $past(rdObjectSubindex, 3))
    else $error("read reply did not echo the request");
  a_value_field: assert property (@(posedge clk) disable iff (sys_rst)
    rdReplyValid |-> rdReplyValue[VALUE_W-1:32] == '0)
    else $error("read value wider than its object");
  a_null_gate: assert property (@(posedge clk) disable iff (sys_rst)
    s_read_taken ##1 (rdReqValid && !rdNull)[*3] |=> !rdReplyValid ##1 !rdReplyValid)
    else $error("request accepted without a null request");
  a_write_echo: assert property (@(posedge clk) disable iff (sys_rst)
    s_write_taken |=> wrReplyValid && wrReplyIndex == $past(wrObjectIndex))
    else $error("write reply did not echo the request");
  a_key_select: assert property (@(posedge clk) disable iff (sys_rst)
    takeWr && wrHits == '0 |=> wrReplyError == ERR_NO_OBJECT && !q.memWe)
    else $error("unknown object was accepted");
  a_rights_held: assert property (@(posedge clk) disable iff (sys_rst)
    wrReplyValid && wrReplyError != ERR_OK |-> !q.memWe)
    else $error("refused write reached the store");
  a_range_check: assert property (@(posedge clk) disable iff (sys_rst)
    takeWr && wrHits != '0 && OBJ_TYPE[wrSlot] == unsigned8_type && OBJ_ACC[wrSlot] != ACC_RO
      && wrValue[15:8] != 8'h00 |=> wrReplyError == ERR_RANGE)
    else $error("out-of-range unsigned8 value accepted");
  a_start_delay: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(measActive) |-> $past(q.startCnt) == 32'(START_CYCLES - 1))
    else $error("measured values started at the wrong time");
  a_one_conn: assert property (@(posedge clk) disable iff (sys_rst)
    (connGrant & connReq) != 2'b00 && (connReq & ~q.connReqPrev & ~connGrant) != 2'b00
      |=> connRejected)
    else $error("second connection not refused");
  a_grant_onehot: assert property (@(posedge clk) disable iff (sys_rst)
    $onehot0(connGrant))
    else $error("more than one connection granted");
  a_keep_net: assert property (@(posedge clk) disable iff (sys_rst)
    q.state == S_IDLE && !rdReqValid && !wrReqValid && importValid && impHits[7]
      |=> !q.memWe)
    else $error("import overwrote network settings");
  a_float_out: assert property (@(posedge clk) disable iff (sys_rst)
    measActive && $past(measActive) |-> measFloatOut == $past(measFloat))
    else $error("measured value not passed through");
  a_reply_hold: assert property (@(posedge clk) disable iff (sys_rst)
    !rdReplyValid |-> $stable(rdReplyIndex) && $stable(rdReplyValue))
    else $error("read reply changed without a new answer");
endmodule
`default_nettype wire

// [fodac_plc_model.sv]
// Fieldbus controller model: per command, one request and then, unless skipNull is set, its null request.
// Assumes the engine answers a taken request within eight cycles.
`default_nettype none
module fodac_plc_model
  import fodac_pkg::*;
(
  input wire logic clk,
  input wire logic go,
  input wire logic isWr,
  input wire logic skipNull,
  input wire logic [2:0] gap,
  input wire logic [23:0] key,
  input wire logic [fodac_pkg::VALUE_W-1:0] val,
  input wire logic rdRepV,
  input wire logic [23:0] rdRepKey,
  input wire logic [7:0] rdRepErr,
  input wire logic [fodac_pkg::VALUE_W-1:0] rdRepValue,
  input wire logic wrRepV,
  input wire logic [23:0] wrRepKey,
  input wire logic [7:0] wrRepErr,
  output logic rdReqValid,
  output logic wrReqValid,
  output logic [23:0] keyLine,
  output logic [fodac_pkg::VALUE_W-1:0] wrValue,
  output logic done,
  output logic gotReply,
  output logic [23:0] capKey,
  output logic [7:0] capErr,
  output logic [fodac_pkg::VALUE_W-1:0] capValue
);
  import fodac_pkg::*;

  // Key and value lines show the inverse once taken, so stale data never passes as valid
  task automatic send(input logic w, input logic [23:0] k, input logic [VALUE_W-1:0] v,
                      input logic keep);
    logic got;
    rdReqValid <= !w;
    wrReqValid <= w;
    keyLine <= k;
    wrValue <= v;
    @(posedge clk);
    rdReqValid <= 1'b0;
    wrReqValid <= 1'b0;
    keyLine <= ~k;
    wrValue <= ~v;
    got = 1'b0;
    for (int i = 0; i < 8 && !got; i++) begin
      @(posedge clk);
      got = w ? wrRepV : rdRepV;
    end
    if (keep) begin
      gotReply <= got;
      capKey <= w ? wrRepKey : rdRepKey;
      capErr <= w ? wrRepErr : rdRepErr;
      capValue <= rdRepValue;
    end
  endtask

  // Random pause before the null request models a slow controller
  initial begin
    rdReqValid = 1'b0;
    wrReqValid = 1'b0;
    keyLine = '1;
    wrValue = '1;
    done = 1'b0;
    gotReply = 1'b0;
    capKey = '0;
    capErr = '0;
    capValue = '0;
    forever begin
      @(posedge clk);
      done <= 1'b0;
      if (go) begin
        send(isWr, key, val, 1'b1);
        repeat (gap) @(posedge clk);
        if (!skipNull) begin
          send(isWr, {NULL_INDEX, NULL_SUBINDEX}, '0, 1'b0);
        end
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [fodac_object_access_bench.sv]
// Self-checking bench for the object dictionary access engine.
// Assumes fodac_pkg, the engine and the controller model are compiled first.
`default_nettype none
module fodac_object_access_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fodac_pkg::*;
`define CHK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      errCount++; \
      $display("ERROR %s expected %0h seen %0h", what, exp, got); \
    end \
  end
  localparam int SIM_START = 20;
  int seed = 32'h58e0;
  int checks = 0;
  int errCount = 0;
  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic cmdGo = 1'b0, cmdWrite = 1'b0, cmdSkip = 1'b0, importValid = 1'b0;
  logic [1:0] connReq = 2'b00;
  logic [2:0] cmdGap = 3'h0;
  logic [23:0] cmdKey = 24'h00_0000, impKey = 24'h00_0000;
  logic [31:0] measFloat = 32'h0000_0000, impValue = 32'h0000_0000;
  logic [VALUE_W-1:0] cmdValue = '0;
  logic [1:0] connGrant;
  logic connRejected, measActive, rdReqValid, wrReqValid, rdReplyValid, wrReplyValid;
  logic done, gotReply, reqReady;
  logic [15:0] rdReplyIndex, wrReplyIndex;
  logic [7:0] rdReplySubindex, wrReplySubindex, rdReplyError, wrReplyError, capErr;
  logic [23:0] keyLine, capKey;
  logic [31:0] measFloatOut;
  logic [VALUE_W-1:0] wrValue, rdReplyValue, capValue;
  logic [31:0] mem [NUM_OBJECTS];

  always #4 clk = ~clk;

  fodac_object_access #(.START_CYCLES(SIM_START)) DUT (
    .clk(clk), .sys_rst(sysRst), .connReq(connReq), .connGrant(connGrant),
    .connRejected(connRejected), .rdReqValid(rdReqValid), .rdObjectIndex(keyLine[23:8]),
    .rdObjectSubindex(keyLine[7:0]), .wrReqValid(wrReqValid), .wrObjectIndex(keyLine[23:8]),
    .wrObjectSubindex(keyLine[7:0]), .wrValue(wrValue), .importValid(importValid),
    .importObjectIndex(impKey[23:8]), .importObjectSubindex(impKey[7:0]),
    .importValue(impValue), .measFloat(measFloat), .measFloatOut(measFloatOut),
    .measActive(measActive), .reqReady(reqReady), .rdReplyValid(rdReplyValid),
    .rdReplyIndex(rdReplyIndex), .rdReplySubindex(rdReplySubindex),
    .rdReplyError(rdReplyError), .rdReplyValue(rdReplyValue), .wrReplyValid(wrReplyValid),
    .wrReplyIndex(wrReplyIndex), .wrReplySubindex(wrReplySubindex),
    .wrReplyError(wrReplyError));

  fodac_plc_model ctrl (
    .clk(clk), .go(cmdGo), .isWr(cmdWrite), .skipNull(cmdSkip), .gap(cmdGap), .key(cmdKey),
    .val(cmdValue), .rdRepV(rdReplyValid), .rdRepKey({rdReplyIndex, rdReplySubindex}),
    .rdRepErr(rdReplyError), .rdRepValue(rdReplyValue), .wrRepV(wrReplyValid),
    .wrRepKey({wrReplyIndex, wrReplySubindex}), .wrRepErr(wrReplyError),
    .rdReqValid(rdReqValid), .wrReqValid(wrReqValid), .keyLine(keyLine), .wrValue(wrValue),
    .done(done), .gotReply(gotReply), .capKey(capKey), .capErr(capErr), .capValue(capValue));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  function automatic int slotOf(logic [23:0] k);
    for (int i = 0; i < NUM_OBJECTS; i++) begin
      if (OBJ_KEY[i] === k) return i;
    end
    return -1;
  endfunction

  // Expected error code; a value must fit its encoding, bits above it clear
  function automatic logic [7:0] expErr(logic w, logic [23:0] k, logic [VALUE_W-1:0] v);
    int s;
    logic [VALUE_W-1:0] top;
    s = slotOf(k);
    if (s < 0) return ERR_NO_OBJECT;
    if (OBJ_ACC[s] == (w ? ACC_RO : ACC_WO)) return ERR_ACCESS;
    if (!w) return ERR_OK;
    case (OBJ_TYPE[s])
      unsigned8_type: top = v >> 8;
      unsigned16_type: top = v >> 16;
      boolean_type: top = v >> 1;
      signed16_type: top = (v >> 32) | VALUE_W'(v[31:16] != {16{v[15]}});
      default: top = v >> 32;
    endcase
    return (top == '0) ? ERR_OK : ERR_RANGE;
  endfunction

  // Hand one command to the controller model and wait, bounded, for it to finish
  task automatic op(input logic w, input logic [23:0] k, input logic [VALUE_W-1:0] v,
                    input logic skip);
    int n;
    @(posedge clk);
    cmdWrite <= w;
    cmdKey <= k;
    cmdValue <= v;
    cmdSkip <= skip;
    cmdGap <= 3'($random(seed));
    cmdGo <= 1'b1;
    @(posedge clk);
    cmdGo <= 1'b0;
    n = 0;
    while (done !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 60) begin
        errCount++;
        $display("ERROR controller done timeout");
        wrap_up();
      end
    end
  endtask

  task automatic access(input logic w, input logic [23:0] k, input logic [VALUE_W-1:0] v,
                        input logic skip);
    logic [7:0] e;
    logic [VALUE_W-1:0] kept;
    int s;
    kept = rdReplyValue;
    e = expErr(w, k, v);
    s = slotOf(k);
    op(w, k, v, skip);
    `CHK("reply seen", 1'b1, gotReply)
    `CHK("reply key", k, capKey)
    `CHK("reply error", e, capErr)
    if (w) begin
      `CHK("read reply kept", kept, rdReplyValue)
      if (e == ERR_OK) mem[s] = v[31:0];
    end else if (e == ERR_OK) begin
      `CHK("read value", {{(VALUE_W-32){1'b0}}, mem[s]}, capValue)
    end
  endtask

  // Archive entries go in only while idle; network settings must survive
  task automatic importOne(input logic [23:0] k, input logic [31:0] v);
    int s;
    s = slotOf(k);
    @(posedge clk);
    importValid <= 1'b1;
    impKey <= k;
    impValue <= v;
    @(posedge clk);
    importValid <= 1'b0;
    if (!OBJ_KEEP[s]) mem[s] = v;
  endtask

  initial begin
    int n;
    int i;
    logic [VALUE_W-1:0] v;
    for (int j = 0; j < NUM_OBJECTS; j++) mem[j] = OBJ_RESET[j];
    repeat (20) @(posedge clk);
    #1;
    `CHK("grant in reset", 2'b00, connGrant)
    `CHK("active in reset", 1'b0, measActive)
    @(posedge clk);
    sysRst <= 1'b0;
    connReq <= 2'b10;
    n = 0;
    while (measActive !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK("start delay", 1'b1, n >= SIM_START && n <= SIM_START + 12)
    `CHK("fieldbus grant", 2'b10, connGrant)
    `CHK("ready after start", 1'b1, reqReady)
    @(posedge clk);
    connReq <= 2'b11;
    @(posedge clk);
    #1;
    `CHK("second link refused", 1'b1, connRejected)
    `CHK("owner kept", 2'b10, connGrant)
    @(posedge clk);
    connReq <= 2'b10;
    // Measured values pass as raw float words one cycle late
    repeat (4) begin
      @(posedge clk);
      measFloat <= $random(seed);
      @(posedge clk);
      #1;
      `CHK("measured float", measFloat, measFloatOut)
    end
    $display("test startup and link done");
    for (int j = 0; j < NUM_OBJECTS; j++) access(1'b0, OBJ_KEY[j], '0, 1'b0);
    access(1'b0, {16'h2010, 8'h08}, '0, 1'b0);
    access(1'b1, {16'h2011, 8'h07}, 320'h0005, 1'b0);
    access(1'b1, {16'h3002, 8'h02}, 320'h0001, 1'b0);
    access(1'b1, {16'h2010, 8'h07}, 320'h0100, 1'b0);
    access(1'b1, {16'h2010, 8'h17}, 320'h1_0000, 1'b0);
    access(1'b1, {16'h1010, 8'h01}, 320'h1_0000_0000, 1'b0);
    $display("test fixed accesses done");
    repeat (24) begin
      i = $unsigned($random(seed)) % NUM_OBJECTS;
      v = VALUE_W'($unsigned($random(seed))) >> ($unsigned($random(seed)) % 32);
      access(1'b1, OBJ_KEY[i], v, 1'b0);
      access(1'b0, OBJ_KEY[i], '0, 1'b0);
    end
    $display("test random accesses done");
    // Without the null request the next write must be dropped
    access(1'b0, {16'h2010, 8'h17}, '0, 1'b1);
    repeat (3) @(posedge clk);
    `CHK("reply held", {16'h2010, 8'h17}, {rdReplyIndex, rdReplySubindex})
    `CHK("busy without null", 1'b0, reqReady)
    op(1'b1, {16'h2010, 8'h07}, 320'h0002, 1'b0);
    `CHK("request dropped", 1'b0, gotReply)
    access(1'b0, {16'h2010, 8'h07}, '0, 1'b0);
    $display("test null request done");
    importOne({16'h1010, 8'h01}, $random(seed));
    importOne({16'h2100, 8'h01}, 32'h1234_5678);
    access(1'b0, {16'h1010, 8'h01}, '0, 1'b0);
    access(1'b0, {16'h2100, 8'h01}, '0, 1'b0);
    $display("test import done");
    wrap_up();
  end
endmodule
`default_nettype wire
